/* core/aiet_cfg.svh */
// Constants for the analog input event transmitter: object indices, resets, fields, sizes
`ifndef AIET_CFG_SVH
`define AIET_CFG_SVH

// ************************************************************
// Object dictionary indices
// ************************************************************
`define AIET_IDX_AIN_VAL 16'h6401
`define AIET_IDX_AOUT_VAL 16'h6411
`define AIET_IDX_TRIG_SEL 16'h6421
`define AIET_IDX_GLOBAL_EN 16'h6423
`define AIET_IDX_UPPER 16'h6424
`define AIET_IDX_LOWER 16'h6425
`define AIET_IDX_DELTA_ANY 16'h6426
`define AIET_IDX_DELTA_NEG 16'h6427
`define AIET_IDX_DELTA_POS 16'h6428

// ************************************************************
// Reset values
// ************************************************************
`define AIET_RST_AOUT 16'h0000
`define AIET_RST_TRIG 8'h07
`define AIET_RST_GLOBAL_EN 8'h00
`define AIET_RST_LIMIT 16'h0000
`define AIET_RST_DELTA 16'h0000

// ************************************************************
// Trigger-selection fields and global enable value
// ************************************************************
`define AIET_TRIG_UPPER_BIT 0
`define AIET_TRIG_LOWER_BIT 1
`define AIET_TRIG_ANY_BIT 2
`define AIET_TRIG_NEG_BIT 3
`define AIET_TRIG_POS_BIT 4
`define AIET_TRIG_USED_MASK 8'h1f
`define AIET_GLOBAL_EN_ON 8'h01

// ************************************************************
// Sizes and transmission types
// ************************************************************
`define AIET_NUM_CHAN 16
`define AIET_FIFO_DEPTH 8
`define AIET_TXTYPE_ASYNC_MFR 8'hfe
`define AIET_TXTYPE_ASYNC_PROF 8'hff

`endif

/* core/aiet_pkg.sv */
// Types shared by the analog input event transmitter
package aiet_pkg;

  typedef enum logic [0:0] {
    AIET_ST_RUN = 1'b0,
    AIET_ST_SWEEP = 1'b1
  } aiet_state_t;

  typedef logic [3:0] aiet_chan_t;

endpackage : aiet_pkg

/* core/aiet_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module aiet_fifo #(
  parameter int W = 20,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count
  assign in_ready_o = (count_reg != (AW+1)'(D));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o = mem_reg[rd_ptr_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage has no reset; only the pointers and the count decide what is valid
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(D-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(D-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule : aiet_fifo

/* core/aiet_trig_eval.sv */
// Per-sample trigger evaluation against thresholds and the last sent value
`timescale 1ns/1ps
`include "aiet_cfg.svh"
module aiet_trig_eval (
  input wire logic [15:0] value_i,
  input wire logic [15:0] last_i,
  input wire logic [7:0] sel_i,
  input wire logic [15:0] upper_i,
  input wire logic [15:0] lower_i,
  input wire logic [15:0] delta_any_i,
  input wire logic [15:0] delta_neg_i,
  input wire logic [15:0] delta_pos_i,
  output logic fire_o
);

  logic rise;
  logic [15:0] up_diff;
  logic [15:0] down_diff;
  logic thr_sel;
  logic thr_hit;
  logic dlt_sel;
  logic dlt_hit;

  // Differences are taken in the direction that cannot wrap
  assign rise = (value_i > last_i);
  assign up_diff = value_i - last_i;
  assign down_diff = last_i - value_i;

  // Threshold conditions; upper limit is taken as a transmit condition
  assign thr_sel = sel_i[`AIET_TRIG_UPPER_BIT] || sel_i[`AIET_TRIG_LOWER_BIT];
  assign thr_hit = (sel_i[`AIET_TRIG_UPPER_BIT] && (value_i >= upper_i)) ||
                   (sel_i[`AIET_TRIG_LOWER_BIT] && (value_i <= lower_i));

  // Delta conditions against the retained last transmitted value
  assign dlt_sel = sel_i[`AIET_TRIG_ANY_BIT] || sel_i[`AIET_TRIG_NEG_BIT] ||
                   sel_i[`AIET_TRIG_POS_BIT];
  assign dlt_hit =
    (sel_i[`AIET_TRIG_ANY_BIT] && ((rise ? up_diff : down_diff) >= delta_any_i)) ||
    (sel_i[`AIET_TRIG_NEG_BIT] && !rise && (down_diff >= delta_neg_i)) ||
    (sel_i[`AIET_TRIG_POS_BIT] && rise && (up_diff > delta_pos_i));

  // Threshold and delta both selected: both must hold, else any one suffices
  assign fire_o = (thr_sel && dlt_sel) ? (thr_hit && dlt_hit)
                                       : (thr_hit || dlt_hit);

endmodule : aiet_trig_eval

/* core/aiet_core.sv */
// Analog process-data image with event-driven transmit queue
// Operation
// - Up to sixteen read-only 16-bit input values, index 1 nearest the coupler.
// - Up to sixteen writable 16-bit output values, cleared to zero at reset.
// - Sub-index zero of each array reads the present channel count, read-only.
// - Global enable 1 allows event transmission; any other value blocks events, but not the entry sweep.
// - Global enable resets to zero, so event transmission starts off.
// - Per-channel 8-bit trigger byte, default 7; bits 5 to 7 reserved.
// - Bit 0: input greater or equal to upper limit triggers transmission.
// - Bit 1: input less or equal to lower limit triggers transmission.
// - Bit 2: change from last sent value by at least delta, either way.
// - Bit 3: fall below last sent value by at least negative delta.
// - Bit 4: rise above last sent value by more than positive delta.
// - Last sent value kept per channel; delta settings 16-bit, default zero.
// - Threshold and delta both selected: send only when both hold.
// - Process data leaves only in the operational state.
// - On entering operational with type 254 or 255, send every present input channel once.
`timescale 1ns/1ps
`include "aiet_cfg.svh"
module aiet_core
  import aiet_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Object dictionary access, one request per cycle
  input wire logic od_rd_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_subidx_i,
  input wire logic [15:0] od_wdata_i,
  output logic od_ack_o,
  output logic od_err_o,
  output logic [15:0] od_rdata_o,
  // Channel counts from the rail scan
  input wire logic [7:0] ain_count_i,
  input wire logic [7:0] aout_count_i,
  // Input samples from the internal bus
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [3:0] sample_chan_i,
  input wire logic [15:0] sample_data_i,
  // Network state and transmit PDO type
  input wire logic operational_i,
  input wire logic [7:0] tx_type_i,
  // Output image
  output logic [16*`AIET_NUM_CHAN-1:0] aout_o,
  // Transmit queue toward the PDO engine
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  output logic [3:0] tx_chan_o,
  output logic [15:0] tx_data_o
);

  localparam int NCH = `AIET_NUM_CHAN;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [15:0] ain_reg [NCH];
  logic [15:0] aout_reg [NCH];
  logic [7:0] trig_reg [NCH];
  logic [15:0] upper_reg [NCH];
  logic [15:0] lower_reg [NCH];
  logic [15:0] dany_reg [NCH];
  logic [15:0] dneg_reg [NCH];
  logic [15:0] dpos_reg [NCH];
  logic [15:0] last_reg [NCH];
  logic [7:0] gen_reg;
  aiet_state_t state_reg;
  aiet_chan_t sweep_reg;
  logic op_reg;

  logic sub_ok;
  logic [3:0] sub_ch;
  logic [7:0] cnt_sel;
  logic rd_err;
  logic [15:0] rd_val;
  logic wr_ok;
  logic fire;
  logic sample_take;
  logic q_in_valid;
  logic q_in_ready;
  logic [19:0] q_in_data;
  logic [19:0] q_out_data;
  logic q_out_valid;
  logic q_out_ready;
  logic push;
  logic sweep_push;
  logic sweep_last;
  logic op_rise;

  // ************************************************************
  // Address decode
  // ************************************************************

  // Sub-indices 1..16 map to channels 0..15 counted outward from the coupler
  assign sub_ch = 4'(od_subidx_i - 8'h01);
  assign cnt_sel = (od_index_i == `AIET_IDX_AOUT_VAL) ? aout_count_i : ain_count_i;
  assign sub_ok = (od_subidx_i != 8'h00) && (od_subidx_i <= cnt_sel) &&
                  (od_subidx_i <= 8'(NCH));

  // Read mux; sub-index zero of every array returns its channel count
  always_comb begin
    rd_err = 1'b0;
    rd_val = 16'h0000;
    if (od_index_i == `AIET_IDX_GLOBAL_EN) begin
      rd_err = (od_subidx_i != 8'h00);
      rd_val = {8'h00, gen_reg};
    end else if (od_subidx_i == 8'h00) begin
      rd_val = {8'h00, cnt_sel};
      unique case (od_index_i)
        `AIET_IDX_AIN_VAL, `AIET_IDX_AOUT_VAL, `AIET_IDX_TRIG_SEL, `AIET_IDX_UPPER,
        `AIET_IDX_LOWER, `AIET_IDX_DELTA_ANY, `AIET_IDX_DELTA_NEG,
        `AIET_IDX_DELTA_POS: rd_err = 1'b0;
        default: rd_err = 1'b1;
      endcase
    end else if (!sub_ok) begin
      rd_err = 1'b1;
    end else begin
      unique case (od_index_i)
        `AIET_IDX_AIN_VAL: rd_val = ain_reg[sub_ch];
        `AIET_IDX_AOUT_VAL: rd_val = aout_reg[sub_ch];
        `AIET_IDX_TRIG_SEL: rd_val = {8'h00, trig_reg[sub_ch]};
        `AIET_IDX_UPPER: rd_val = upper_reg[sub_ch];
        `AIET_IDX_LOWER: rd_val = lower_reg[sub_ch];
        `AIET_IDX_DELTA_ANY: rd_val = dany_reg[sub_ch];
        `AIET_IDX_DELTA_NEG: rd_val = dneg_reg[sub_ch];
        `AIET_IDX_DELTA_POS: rd_val = dpos_reg[sub_ch];
        default: rd_err = 1'b1;
      endcase
    end
  end

  // Writes are refused on counts, on input values and on absent channels
  always_comb begin
    wr_ok = 1'b0;
    if (od_index_i == `AIET_IDX_GLOBAL_EN) begin
      wr_ok = (od_subidx_i == 8'h00);
    end else if (sub_ok) begin
      unique case (od_index_i)
        `AIET_IDX_AOUT_VAL, `AIET_IDX_TRIG_SEL, `AIET_IDX_UPPER, `AIET_IDX_LOWER,
        `AIET_IDX_DELTA_ANY, `AIET_IDX_DELTA_NEG, `AIET_IDX_DELTA_POS: wr_ok = 1'b1;
        default: wr_ok = 1'b0;
      endcase
    end
  end

  // Answer one cycle after the request; write wins when both strobes rise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      od_ack_o <= 1'b0;
      od_err_o <= 1'b0;
      od_rdata_o <= 16'h0000;
    end else begin
      od_ack_o <= od_rd_i || od_wr_i;
      od_err_o <= od_wr_i ? !wr_ok : (od_rd_i && rd_err);
      if (od_rd_i && !od_wr_i && !rd_err) begin
        od_rdata_o <= rd_val;
      end
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************

  // Global enable defaults to off so the bus is not flooded at start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gen_reg <= `AIET_RST_GLOBAL_EN;
    end else if (od_wr_i && wr_ok && od_index_i == `AIET_IDX_GLOBAL_EN) begin
      gen_reg <= od_wdata_i[7:0];
    end
  end

  // Per-channel settings, one generate entry per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic hit;
    assign hit = od_wr_i && wr_ok && (sub_ch == 4'(c));

    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        aout_reg[c] <= `AIET_RST_AOUT;
        trig_reg[c] <= `AIET_RST_TRIG;
        upper_reg[c] <= `AIET_RST_LIMIT;
        lower_reg[c] <= `AIET_RST_LIMIT;
        dany_reg[c] <= `AIET_RST_DELTA;
        dneg_reg[c] <= `AIET_RST_DELTA;
        dpos_reg[c] <= `AIET_RST_DELTA;
      end else if (hit) begin
        unique case (od_index_i)
          `AIET_IDX_AOUT_VAL: aout_reg[c] <= od_wdata_i;
          `AIET_IDX_TRIG_SEL: trig_reg[c] <= od_wdata_i[7:0] & `AIET_TRIG_USED_MASK;
          `AIET_IDX_UPPER: upper_reg[c] <= od_wdata_i;
          `AIET_IDX_LOWER: lower_reg[c] <= od_wdata_i;
          `AIET_IDX_DELTA_ANY: dany_reg[c] <= od_wdata_i;
          `AIET_IDX_DELTA_NEG: dneg_reg[c] <= od_wdata_i;
          `AIET_IDX_DELTA_POS: dpos_reg[c] <= od_wdata_i;
          default: aout_reg[c] <= aout_reg[c];
        endcase
      end
    end

    assign aout_o[16*c +: 16] = aout_reg[c];
  end

  // ************************************************************
  // Sample capture and trigger evaluation
  // ************************************************************

  // Samples stall while the queue is full or the entry sweep runs
  assign sample_ready_o = q_in_ready && (state_reg == AIET_ST_RUN);
  assign sample_take = sample_valid_i && sample_ready_o;

  // Input image follows every sample, sent or not
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        ain_reg[i] <= 16'h0000;
      end
    end else if (sample_take) begin
      ain_reg[sample_chan_i] <= sample_data_i;
    end
  end

  aiet_trig_eval u_eval (
    .value_i(sample_data_i),
    .last_i(last_reg[sample_chan_i]),
    .sel_i(trig_reg[sample_chan_i]),
    .upper_i(upper_reg[sample_chan_i]),
    .lower_i(lower_reg[sample_chan_i]),
    .delta_any_i(dany_reg[sample_chan_i]),
    .delta_neg_i(dneg_reg[sample_chan_i]),
    .delta_pos_i(dpos_reg[sample_chan_i]),
    .fire_o(fire)
  );

  // Event push needs the global enable at 1 and the operational state
  assign push = sample_take && fire && operational_i &&
                (gen_reg == `AIET_GLOBAL_EN_ON);

  // ************************************************************
  // Entry sweep on becoming operational
  // ************************************************************
  assign op_rise = operational_i && !op_reg;
  assign sweep_push = (state_reg == AIET_ST_SWEEP) && operational_i &&
                      (8'(sweep_reg) < ain_count_i);
  assign sweep_last = (sweep_reg == 4'(NCH-1)) || (8'(sweep_reg) + 8'h01 >= ain_count_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_reg <= 1'b0;
    end else begin
      op_reg <= operational_i;
    end
  end

  // Sweep walks every present channel once; leaving operational aborts it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= AIET_ST_RUN;
      sweep_reg <= '0;
    end else begin
      unique case (state_reg)
        AIET_ST_RUN: begin
          if (op_rise && (tx_type_i == `AIET_TXTYPE_ASYNC_MFR ||
                          tx_type_i == `AIET_TXTYPE_ASYNC_PROF) &&
              ain_count_i != 8'h00) begin
            state_reg <= AIET_ST_SWEEP;
            sweep_reg <= '0;
          end
        end
        AIET_ST_SWEEP: begin
          if (!operational_i || !sweep_push) begin
            state_reg <= AIET_ST_RUN;
          end else if (q_in_ready) begin
            sweep_reg <= sweep_reg + 4'h1;
            if (sweep_last) begin
              state_reg <= AIET_ST_RUN;
            end
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Transmit queue
  // ************************************************************
  assign q_in_valid = push || sweep_push;
  assign q_in_data = sweep_push ? {sweep_reg, ain_reg[sweep_reg]}
                                : {sample_chan_i, sample_data_i};

  // Last sent value updates when the entry is accepted into the queue
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        last_reg[i] <= 16'h0000;
      end
    end else if (q_in_valid && q_in_ready) begin
      last_reg[q_in_data[19:16]] <= q_in_data[15:0];
    end
  end

  aiet_fifo #(
    .W(20),
    .D(`AIET_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(q_in_valid),
    .in_ready_o(q_in_ready),
    .in_data_i(q_in_data),
    .out_valid_o(q_out_valid),
    .out_ready_i(q_out_ready),
    .out_data_o(q_out_data)
  );

  // Queue drains only while operational; entries wait otherwise
  assign tx_valid_o = q_out_valid && operational_i;
  assign q_out_ready = tx_ready_i && operational_i;
  assign tx_chan_o = q_out_data[19:16];
  assign tx_data_o = q_out_data[15:0];

endmodule : aiet_core

/* test/aiet_core_props.sv */
// Concurrent checks on the ports of the analog input event transmitter
`timescale 1ns/1ps
`include "aiet_cfg.svh"
module aiet_core_props
  import aiet_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic od_rd_i,
  input wire logic od_wr_i,
  input wire logic [15:0] od_index_i,
  input wire logic [7:0] od_subidx_i,
  input wire logic [15:0] od_wdata_i,
  input wire logic od_ack_o,
  input wire logic od_err_o,
  input wire logic [7:0] aout_count_i,
  input wire logic operational_i,
  input wire logic [16*`AIET_NUM_CHAN-1:0] aout_o,
  input wire logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic [3:0] tx_chan_o,
  input wire logic [15:0] tx_data_o
);
  // ********************
  // Object access and transmit queue
  // ********************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_ack_next: assert property ((od_rd_i || od_wr_i) |=> od_ack_o)
    else $error("request without answer");
  a_ack_only: assert property (!(od_rd_i || od_wr_i) |=> !od_ack_o && !od_err_o)
    else $error("answer without request");
  a_ro_write: assert property (od_wr_i && od_index_i == `AIET_IDX_AIN_VAL |=> od_err_o)
    else $error("input value write not refused");
  a_count_write: assert property (od_wr_i && od_subidx_i == 8'h00
    && od_index_i != `AIET_IDX_GLOBAL_EN |=> od_err_o) else $error("count write not refused");
  a_enable_sub: assert property (od_index_i == `AIET_IDX_GLOBAL_EN
    && od_subidx_i != 8'h00 && (od_rd_i || od_wr_i) |=> od_err_o) else $error("bad enable sub");
  a_aout_store: assert property (od_wr_i && od_index_i == `AIET_IDX_AOUT_VAL
    && od_subidx_i == 8'h01 && aout_count_i != 8'h00 |=> aout_o[15:0] == $past(od_wdata_i))
    else $error("output value not stored");
  a_aout_keep: assert property (!od_wr_i |=> $stable(aout_o))
    else $error("output image changed without write");
  a_tx_oper: assert property (tx_valid_o |-> operational_i)
    else $error("transmit outside operational state");
  a_head_hold: assert property (tx_valid_o && !tx_ready_i |=> $stable({tx_chan_o, tx_data_o}))
    else $error("queue head changed before pop");
endmodule : aiet_core_props

/* test/aiet_pdo_sink.sv */
// Transmit consumer model standing for the bus master side of the queue
`timescale 1ns/1ps
module aiet_pdo_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic slow_i,
  output logic tx_ready_o
);
  logic tog_reg;

  // Toggle gives a half-rate consumer, so pops and stalls interleave
  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tog_reg <= 1'b0;
    else tog_reg <= ~tog_reg;
  end
  assign tx_ready_o = !stall_i && (!slow_i || tog_reg);
endmodule : aiet_pdo_sink

/* test/tb_aiet_core.sv */
// Self-checking bench for the analog input event transmitter
`timescale 1ns/1ps
`include "aiet_cfg.svh"
module tb_aiet_core
  import aiet_pkg::*;
;
  logic clk_i = 1'b0, rst_n_i = 1'b0, od_rd_i = 1'b0, od_wr_i = 1'b0, sample_valid_i = 1'b0;
  logic operational_i = 1'b0, sink_stall = 1'b0, sink_slow = 1'b0;
  logic [15:0] od_index_i = 16'h0000, od_wdata_i = 16'h0000, sample_data_i = 16'h0000;
  logic [7:0] od_subidx_i = 8'h00, ain_count_i = 8'h04, aout_count_i = 8'h02, tx_type_i = 8'h01;
  logic [3:0] sample_chan_i = 4'h0;
  logic od_ack_o, od_err_o, sample_ready_o, tx_valid_o, tx_ready_i;
  logic [15:0] od_rdata_o, tx_data_o, rnd;
  logic [3:0] tx_chan_o;
  logic [16*`AIET_NUM_CHAN-1:0] aout_o;
  logic [19:0] exp_q [$];
  // Access notes: {read data compared, error expected, read data}
  logic [17:0] od_q [$];
  logic [17:0] od_n;
  logic [15:0] img [16] = '{default: 16'h0000};
  // Channel 1 steps: {index, value, fires}; index zero means a sample
  logic [32:0] steps [26] = '{{16'h6421, 16'h0004, 1'b0}, {16'h6426, 16'h0010, 1'b0},
    {16'h0, 16'h000f, 1'b0}, {16'h0, 16'h0010, 1'b1}, {16'h0, 16'h0001, 1'b0},
    {16'h0, 16'h0000, 1'b1}, {16'h6421, 16'h0010, 1'b0}, {16'h6428, 16'h0005, 1'b0},
    {16'h0, 16'h0005, 1'b0}, {16'h0, 16'h0006, 1'b1}, {16'h6421, 16'h0008, 1'b0},
    {16'h6427, 16'h0005, 1'b0}, {16'h0, 16'h0002, 1'b0}, {16'h0, 16'h0001, 1'b1},
    {16'h6421, 16'h0005, 1'b0}, {16'h6424, 16'h0800, 1'b0}, {16'h0, 16'h0900, 1'b1},
    {16'h0, 16'h0905, 1'b0}, {16'h0, 16'h0100, 1'b0}, {16'h6421, 16'h0002, 1'b0},
    {16'h6425, 16'h0200, 1'b0}, {16'h0, 16'h0201, 1'b0}, {16'h0, 16'h0200, 1'b1},
    {16'h6421, 16'h0001, 1'b0}, {16'h0, 16'h07ff, 1'b0}, {16'h0, 16'h0800, 1'b1}};
  int err_total = 0;
  int tests_run = 0;

  always #2.5 clk_i = ~clk_i;

  aiet_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .od_rd_i(od_rd_i), .od_wr_i(od_wr_i),
    .od_index_i(od_index_i), .od_subidx_i(od_subidx_i), .od_wdata_i(od_wdata_i),
    .od_ack_o(od_ack_o), .od_err_o(od_err_o), .od_rdata_o(od_rdata_o),
    .ain_count_i(ain_count_i), .aout_count_i(aout_count_i), .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o), .sample_chan_i(sample_chan_i),
    .sample_data_i(sample_data_i), .operational_i(operational_i), .tx_type_i(tx_type_i),
    .aout_o(aout_o), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
    .tx_chan_o(tx_chan_o), .tx_data_o(tx_data_o));
  aiet_pdo_sink u_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(sink_stall),
    .slow_i(sink_slow), .tx_ready_o(tx_ready_i));

  // ********************
  // Shared tasks
  // ********************
  task check(input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // One object access; the expected answer is noted for the answer monitor
  task od(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [15:0] wd, input logic e, input logic [15:0] exp);
    @(negedge clk_i);
    od_wr_i = wr;
    od_rd_i = !wr;
    od_index_i = idx;
    od_subidx_i = sub;
    od_wdata_i = wd;
    od_q.push_back({!wr && !e, e, exp});
    @(negedge clk_i);
    od_wr_i = 1'b0;
    od_rd_i = 1'b0;
  endtask : od

  // Answers are looked at mid-cycle, where the registered outputs are settled
  always @(negedge clk_i) begin
    if (od_ack_o === 1'b1 && od_q.size() != 0) begin
      od_n = od_q.pop_front();
      check(od_err_o, od_n[16]);
      if (od_n[17]) check(od_rdata_o, od_n[15:0]);
    end else if (od_ack_o !== 1'b0) begin
      check(1'b1, 1'b0);
    end
  end

  // One sample; the expected transmit is noted before the design can queue it
  task smp(input logic [3:0] ch, input logic [15:0] v, input logic f);
    int i;
    @(negedge clk_i);
    for (i = 0; i < 100 && sample_ready_o !== 1'b1; i++) @(negedge clk_i);
    if (i == 100) begin
      err_total++;
      print_verdict();
    end
    sample_valid_i = 1'b1;
    sample_chan_i = ch;
    sample_data_i = v;
    img[ch] = v;
    if (f) exp_q.push_back({ch, v});
    @(negedge clk_i);
    sample_valid_i = 1'b0;
  endtask : smp

  // Bounded wait until every noted transmit has been seen
  task drain;
    int i;
    for (i = 0; i < 300 && (exp_q.size() != 0 || tx_valid_o !== 1'b0); i++) @(negedge clk_i);
    if (i == 300) begin
      err_total++;
      print_verdict();
    end
  endtask : drain

  // Every pop takes the oldest note; a pop with no note is a stray transmit
  always @(posedge clk_i) begin
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check(1'b1, 1'b0);
      else check({tx_chan_o, tx_data_o}, exp_q.pop_front());
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    rnd = 16'($urandom(32'h35cd7ed5));
    repeat (12) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    operational_i = 1'b1;
    od(1'b0, 16'h6401, 8'h00, 16'h0, 1'b0, 16'h0004);
    od(1'b0, 16'h6411, 8'h00, 16'h0, 1'b0, 16'h0002);
    od(1'b0, 16'h6411, 8'h01, 16'h0, 1'b0, 16'h0000);
    od(1'b0, 16'h6421, 8'h01, 16'h0, 1'b0, 16'h0007);
    od(1'b0, 16'h6423, 8'h00, 16'h0, 1'b0, 16'h0000);
    for (int i = 4; i < 8; i++) od(1'b0, 16'h6420 + 16'(i), 8'h04, 16'h0, 1'b0, 16'h0);
    od(1'b1, 16'h6401, 8'h01, 16'h1234, 1'b1, 16'h0);
    od(1'b0, 16'h6400, 8'h01, 16'h0, 1'b1, 16'h0);
    od(1'b0, 16'h6401, 8'h05, 16'h0, 1'b1, 16'h0);
    od(1'b1, 16'h6421, 8'h00, 16'h0003, 1'b1, 16'h0);
    od(1'b0, 16'h6423, 8'h01, 16'h0, 1'b1, 16'h0);
    od(1'b1, 16'h6421, 8'h02, 16'h00ff, 1'b0, 16'h0);
    od(1'b0, 16'h6421, 8'h02, 16'h0, 1'b0, 16'h001f);
    od(1'b1, 16'h6411, 8'h02, rnd, 1'b0, 16'h0);
    od(1'b0, 16'h6411, 8'h02, 16'h0, 1'b0, rnd);
    check(aout_o[31:16], rnd);
    smp(4'h0, 16'h0123, 1'b0);
    od(1'b0, 16'h6401, 8'h01, 16'h0, 1'b0, 16'h0123);
    od(1'b1, 16'h6423, 8'h00, 16'h0002, 1'b0, 16'h0);
    smp(4'h0, 16'h0124, 1'b0);
    od(1'b1, 16'h6423, 8'h00, 16'h0001, 1'b0, 16'h0);
    // Trigger kinds on one channel, each at both sides of its boundary
    foreach (steps[i]) begin
      if (steps[i][32:17] == 16'h0) smp(4'h1, steps[i][16:1], steps[i][0]);
      else od(1'b1, steps[i][32:17], 8'h02, steps[i][16:1], 1'b0, 16'h0);
    end
    drain;
    // Fill the queue against a stalled consumer until samples are refused
    sink_stall = 1'b1;
    for (int i = 0; i < 8; i++) smp(4'h0, 16'($urandom), 1'b1);
    check(sample_ready_o, 1'b0);
    sink_stall = 1'b0;
    sink_slow = 1'b1;
    drain;
    // Samples off-line are dropped; entry sweep sends the current image
    for (int j = 0; j < 2; j++) begin
      operational_i = 1'b0;
      smp(4'h2, 16'($urandom), 1'b0);
      tx_type_i = j ? 8'hff : 8'hfe;
      operational_i = 1'b1;
      for (int i = 0; i < 4; i++) exp_q.push_back({4'(i), img[i]});
      drain;
    end
    // An access whose answer never came leaves its note behind
    check(20'(od_q.size()), 20'h00000);
    print_verdict();
  end
endmodule : tb_aiet_core

bind aiet_core aiet_core_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .od_rd_i(od_rd_i),
  .od_wr_i(od_wr_i), .od_index_i(od_index_i), .od_subidx_i(od_subidx_i),
  .od_wdata_i(od_wdata_i), .od_ack_o(od_ack_o), .od_err_o(od_err_o),
  .aout_count_i(aout_count_i), .operational_i(operational_i), .aout_o(aout_o),
  .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_chan_o(tx_chan_o),
  .tx_data_o(tx_data_o));
